// ===== rtl/irq_enable_pkg.sv
// constants, types and notes for the interrupt enable register bank
// ----------------------------------------------------------------------------
// Notes on behaviour
// - the third enable register holds r/w enables for the clock/calendar at bit 14, pin 4 at bit 6, pin 3 at bit 5, second i2c master at bit 2 and second i2c slave at bit 1, cleared at reset, every other bit reads zero.
// - bit 13 of the fourth enable register is a r/w enable for the charge-time measurement request.
// - bit 8 of the fourth enable register is a r/w enable for the low-voltage detector request.
// - bit 3 of the fourth enable register is a r/w enable for the checksum generator request.
// - bit 2 of the fourth enable register is a r/w enable for the second uart error request.
// - bit 1 of the fourth enable register is a r/w enable for the first uart error request.
// - bits 15-14, 12-9, 7-4 and 0 of the fourth enable register read as zero.
// - a stored one lets its source request an interrupt, a stored zero blocks it.
// - every implemented enable bit is cleared by reset, so nothing is enabled after reset.
// ----------------------------------------------------------------------------
package irq_enable_pkg;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam logic [31:0] IE3_ADDR    = 32'h0000_0000;
  localparam logic [31:0] IE4_ADDR    = 32'h0000_0004;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0008;
  localparam logic [31:0] CLEAR_ADDR  = 32'h0000_000c;
  localparam logic [31:0] IRQ_EN_ADDR = 32'h0000_0010;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int unsigned CLOCK_CAL_BIT    = 14;
  localparam int unsigned PIN4_BIT         = 6;
  localparam int unsigned PIN3_BIT         = 5;
  localparam int unsigned I2C2_MASTER_BIT  = 2;
  localparam int unsigned I2C2_SLAVE_BIT   = 1;
  localparam int unsigned CHARGE_TIME_BIT  = 13;
  localparam int unsigned LOW_VOLTAGE_BIT  = 8;
  localparam int unsigned CHECKSUM_BIT     = 3;
  localparam int unsigned UART2_ERROR_BIT  = 2;
  localparam int unsigned UART1_ERROR_BIT  = 1;
  // status, clear and irq enable: third register low half, fourth high half
  localparam int unsigned IE4_STATUS_LSB   = 16;

  localparam logic [15:0] IE3_IMPL_MASK = 16'(
    (1 << CLOCK_CAL_BIT) | (1 << PIN4_BIT) | (1 << PIN3_BIT) |
    (1 << I2C2_MASTER_BIT) | (1 << I2C2_SLAVE_BIT));
  localparam logic [15:0] IE4_IMPL_MASK = 16'(
    (1 << CHARGE_TIME_BIT) | (1 << LOW_VOLTAGE_BIT) | (1 << CHECKSUM_BIT) |
    (1 << UART2_ERROR_BIT) | (1 << UART1_ERROR_BIT));

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [15:0] IE_RESET     = 16'h0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

  // ----------------------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_HOLD,
    BUS_DONE
  } bus_phase_t;

endpackage : irq_enable_pkg

// ===== rtl/ahb_reg_port.sv
// ahb-lite slave front end with one wait state per whole-word nonsequential transfer, none for other transfers
`timescale 1ns/1ps
module ahb_reg_port import irq_enable_pkg::*; (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output logic             wr_stb,
  output logic [31:0]      reg_addr,
  output logic [31:0]      wr_data,
  input  wire logic [31:0] reg_rdata
);

  typedef struct packed {
    bus_phase_t  phase;
    logic        write;
    logic [31:0] addr;
    logic [31:0] rdata;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic        accept;

  // ----------------------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------------------
  // only whole-word nonsequential transfers act; others get okay and no effect
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

  always_comb begin
    next_s = s;
    case (s.phase)
      BUS_HOLD: begin
        // wait state lets hrdata come straight from a flop
        if (!s.write) begin
          next_s.rdata = reg_rdata;
        end
        next_s.phase = BUS_DONE;
      end
      default: begin
        if (accept) begin
          next_s.phase = BUS_HOLD;
          next_s.write = hwrite;
          next_s.addr  = haddr;
        end else begin
          next_s.phase = BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{phase: BUS_IDLE, write: 1'b0, addr: 32'h0000_0000, rdata: RDATA_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = (s.phase != BUS_HOLD);
  assign hresp     = HRESP_OKAY[0];
  assign hrdata    = s.rdata;
  assign wr_stb    = (s.phase == BUS_HOLD) && s.write;
  assign reg_addr  = s.addr;
  assign wr_data   = hwdata;

endmodule : ahb_reg_port

// ===== rtl/interrupt_enable_regs_3_4.sv
// interrupt enable registers three and four with request gating
`timescale 1ns/1ps
module interrupt_enable_regs_3_4 import irq_enable_pkg::*; (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pending flags from the sources
  input  wire logic [15:0] flag3,
  input  wire logic [15:0] flag4,
  // gated requests to the interrupt controller
  output logic [15:0]      req3,
  output logic [15:0]      req4,
  // summary interrupt
  output logic             irq
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ie3;
    logic [15:0] ie4;
    logic [31:0] status;
    logic [31:0] irq_en;
    logic [15:0] req3;
    logic [15:0] req4;
    logic        irq;
  } bank_state_t;

  bank_state_t s;
  bank_state_t next_s;

  logic        wr_stb;
  logic [31:0] reg_addr;
  logic [31:0] wr_data;
  logic [31:0] reg_rdata;
  logic [31:0] clear_bits;
  logic [31:0] gated;

  // ----------------------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------------------
  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hsize     (hsize),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_stb    (wr_stb),
    .reg_addr  (reg_addr),
    .wr_data   (wr_data),
    .reg_rdata (reg_rdata)
  );

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  // unmapped words and the clear register read as zero
  always_comb begin
    if (reg_addr == IE3_ADDR) begin
      reg_rdata = {16'h0000, s.ie3};
    end else if (reg_addr == IE4_ADDR) begin
      reg_rdata = {16'h0000, s.ie4};
    end else if (reg_addr == STATUS_ADDR) begin
      reg_rdata = s.status;
    end else if (reg_addr == IRQ_EN_ADDR) begin
      reg_rdata = s.irq_en;
    end else begin
      reg_rdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // gating and event capture
  // ----------------------------------------------------------------------------
  // enables are zero in unimplemented positions, so those flags never pass
  assign gated = {flag4 & s.ie4, flag3 & s.ie3};

  always_comb begin
    if (wr_stb && (reg_addr == CLEAR_ADDR)) begin
      clear_bits = wr_data;
    end else begin
      clear_bits = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (wr_stb) begin
      if (reg_addr == IE3_ADDR) begin
        next_s.ie3 = wr_data[15:0] & IE3_IMPL_MASK;
      end else if (reg_addr == IE4_ADDR) begin
        next_s.ie4 = wr_data[15:0] & IE4_IMPL_MASK;
      end else if (reg_addr == IRQ_EN_ADDR) begin
        next_s.irq_en = wr_data;
      end
    end
    // a new event wins over a clear in the same cycle
    next_s.status = (s.status & ~clear_bits) | gated;
    next_s.req3   = gated[15:0];
    next_s.req4   = gated[31:IE4_STATUS_LSB];
    next_s.irq    = |(next_s.status & next_s.irq_en);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{ie3: IE_RESET, ie4: IE_RESET, status: STATUS_RESET, irq_en: IRQ_EN_RESET,
             req3: IE_RESET, req4: IE_RESET, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign req3 = s.req3;
  assign req4 = s.req4;
  assign irq  = s.irq;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence wr_ie3_s;
    wr_stb && (reg_addr == IE3_ADDR);
  endsequence

  sequence wr_ie4_s;
    wr_stb && (reg_addr == IE4_ADDR);
  endsequence

  sequence rd_ie4_addr_s;
    hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD) && !hwrite &&
      (haddr == IE4_ADDR);
  endsequence

  sequence rd_ie3_addr_s;
    hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD) && !hwrite &&
      (haddr == IE3_ADDR);
  endsequence

  property ie3_written_p;
    logic [15:0] d;
    (wr_ie3_s, d = wr_data[15:0]) |=>
      (s.ie3[CLOCK_CAL_BIT] == d[CLOCK_CAL_BIT]) && (s.ie3[PIN4_BIT] == d[PIN4_BIT]) &&
      (s.ie3[PIN3_BIT] == d[PIN3_BIT]) && (s.ie3[I2C2_MASTER_BIT] == d[I2C2_MASTER_BIT]) &&
      (s.ie3[I2C2_SLAVE_BIT] == d[I2C2_SLAVE_BIT]);
  endproperty

  ie3_write_a: assert property (ie3_written_p)
    else $error("third enable register did not take the written bits");

  ie3_reserved_a: assert property ((s.ie3 & ~IE3_IMPL_MASK) == 16'h0000)
    else $error("third enable register holds a bit outside its fields");

  ie3_read_a: assert property (rd_ie3_addr_s ##2 hreadyout |->
      hrdata == {16'h0000, $past(s.ie3, 1)})
    else $error("third enable register read back wrong");

  charge_time_bit_a: assert property (wr_ie4_s |=>
      s.ie4[CHARGE_TIME_BIT] == $past(wr_data[CHARGE_TIME_BIT]))
    else $error("charge time enable did not follow the write");

  low_voltage_bit_a: assert property (wr_ie4_s |=>
      s.ie4[LOW_VOLTAGE_BIT] == $past(wr_data[LOW_VOLTAGE_BIT]))
    else $error("low voltage enable did not follow the write");

  checksum_bit_a: assert property (wr_ie4_s |=>
      s.ie4[CHECKSUM_BIT] == $past(wr_data[CHECKSUM_BIT]))
    else $error("checksum enable did not follow the write");

  uart2_error_bit_a: assert property (wr_ie4_s |=>
      s.ie4[UART2_ERROR_BIT] == $past(wr_data[UART2_ERROR_BIT]))
    else $error("second uart error enable did not follow the write");

  uart1_error_bit_a: assert property (wr_ie4_s |=>
      s.ie4[UART1_ERROR_BIT] == $past(wr_data[UART1_ERROR_BIT]))
    else $error("first uart error enable did not follow the write");

  ie4_read_zero_a: assert property (rd_ie4_addr_s ##1 !hreadyout ##1 hreadyout |->
      (hrdata[15:14] == 2'h0) && (hrdata[12:9] == 4'h0) && (hrdata[7:4] == 4'h0) &&
      (hrdata[0] == 1'b0) && (hrdata[31:16] == 16'h0000))
    else $error("fourth enable register read shows an unimplemented bit");

  ie4_hold_a: assert property (!wr_stb |=> $stable(s.ie4) && $stable(s.ie3))
    else $error("enable register changed without a write");

  req_gating_a: assert property (##1 (req3 == $past(flag3 & s.ie3)) &&
      (req4 == $past(flag4 & s.ie4)))
    else $error("request does not match flag gated by its enable");

  blocked_source_a: assert property ((s.ie4[LOW_VOLTAGE_BIT] == 1'b0) [*2] |->
      req4[LOW_VOLTAGE_BIT] == 1'b0)
    else $error("a disabled source still raised its request");

  reset_clear_a: assert property ($past(!hresetn) |->
      (s.ie3 == IE_RESET) && (s.ie4 == IE_RESET) && (req3 == IE_RESET) && (req4 == IE_RESET))
    else $error("enables not clear after reset");

  ignore_reserved_a: assert property (wr_ie4_s ##1 1'b1 |->
      (s.ie4 & ~IE4_IMPL_MASK) == 16'h0000)
    else $error("write reached an unimplemented enable bit");

  // low-voltage position: an implemented source that the bench really raises
  set_beats_clear_a: assert property (gated[IE4_STATUS_LSB + LOW_VOLTAGE_BIT] |=>
      s.status[IE4_STATUS_LSB + LOW_VOLTAGE_BIT])
    else $error("event lost against a clear");

  irq_level_a: assert property (irq == |(s.status & s.irq_en))
    else $error("interrupt output does not follow enabled status");

endmodule : interrupt_enable_regs_3_4

// ===== tb/tb_top.sv
// self-checking testbench for the interrupt enable register bank
`timescale 1ns/1ps
module tb_top import irq_enable_pkg::*;;

  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  typedef struct {
    int          kind;
    logic [31:0] exp;
  } note_t;

  localparam logic [15:0] exp_mask3 = 16'h4066;
  localparam logic [15:0] exp_mask4 = 16'h210e;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] flag3;
  logic [15:0] flag4;
  logic [15:0] req3;
  logic [15:0] req4;
  logic        irq;
  logic        rd_pend;
  logic        obs;
  logic [31:0] seen;
  logic [31:0] v3;
  logic [31:0] v4;
  logic [31:0] f3;
  logic [31:0] f4;
  note_t       nt;
  note_t       notes[$];
  string       kname[4] = '{"hrdata", "req3", "req4", "irq"};
  int          error_cnt;
  int          check_count;
  int          seed;

  // single slave: its ready out is the bus ready
  assign hready = hreadyout;

  interrupt_enable_regs_3_4 i_interrupt_enable_regs_3_4 (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flag3(flag3),
    .flag4(flag4), .req3(req3), .req4(req4), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // --------------------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdat, input logic [2:0] size);
    int n;
    hsel   <= 1'b1;
    haddr  <= addr;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    hsize  <= size;
    n = 0;
    // ready settles by the falling edge and holds through the next rising one
    do begin @(negedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    @(posedge hclk);
    htrans  <= 2'h0;
    hwdata  <= wdat;
    rd_pend <= !wr;
    do begin @(negedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    check_count++;
    if (hready !== 1'b1 || hresp !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH hready_hresp expected 1_0 seen %b_%b", hready, hresp);
    end
    @(posedge hclk);
    rd_pend <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    xfer(1'b1, addr, data, HSIZE_WORD);
  endtask : wr

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    notes.push_back('{0, exp});
    xfer(1'b0, addr, 32'h0, HSIZE_WORD);
  endtask : rd

  // kind 1 req3, 2 req4, 3 irq; looked at on the next falling edge
  task automatic chk(input int kind, input logic [31:0] exp);
    notes.push_back('{kind, exp});
    obs <= 1'b1;
    @(posedge hclk);
    obs <= 1'b0;
    @(posedge hclk);
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------------------
  // watcher: oldest note against the result that just appeared
  // --------------------------------------------------------------------------
  // falling edge: outputs launched by the rising edge have settled
  always @(negedge hclk) begin
    if ((rd_pend === 1'b1 && hready === 1'b1) || obs === 1'b1) begin
      if (notes.size() == 0) begin
        error_cnt++;
        $display("MISMATCH queue expected note seen none");
      end else begin
        nt = notes.pop_front();
        case (nt.kind)
          0: seen = hrdata;
          1: seen = {16'h0, req3};
          2: seen = {16'h0, req4};
          default: seen = {31'h0, irq};
        endcase
        check_count++;
        if (seen !== nt.exp) begin
          error_cnt++;
          $display("MISMATCH %s expected %h seen %h", kname[nt.kind], nt.exp, seen);
        end
      end
    end
  end

  // generous: the whole sequence needs well under a thousand cycles
  initial begin
    #(100 * 5000);
    error_cnt++;
    $display("MISMATCH watchdog expected finish seen timeout");
    summarize();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    seed = 78842;
    error_cnt = 0;
    check_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    hwrite = 1'b0;
    hwdata = 32'h0;
    flag3 = 16'h0;
    flag4 = 16'h0;
    rd_pend = 1'b0;
    obs = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(IE3_ADDR, 32'h0);
    rd(IE4_ADDR, 32'h0);
    rd(STATUS_ADDR, 32'h0);
    chk(3, 32'h0);
    // walking one with junk in the upper half
    for (int i = 0; i < 16; i++) begin
      wr(IE3_ADDR, 32'hffff_0000 | (32'h1 << i));
      rd(IE3_ADDR, (32'h1 << i) & {16'h0, exp_mask3});
      wr(IE4_ADDR, 32'hffff_0000 | (32'h1 << i));
      rd(IE4_ADDR, (32'h1 << i) & {16'h0, exp_mask4});
    end
    for (int i = 0; i < 12; i++) begin
      v3 = $random(seed);
      v4 = $random(seed);
      f3 = $random(seed);
      f4 = $random(seed);
      flag3 <= f3[15:0];
      flag4 <= f4[15:0];
      wr(IE3_ADDR, v3);
      wr(IE4_ADDR, v4);
      rd(IE3_ADDR, {16'h0, v3[15:0] & exp_mask3});
      rd(IE4_ADDR, {16'h0, v4[15:0] & exp_mask4});
      chk(1, {16'h0, f3[15:0] & v3[15:0] & exp_mask3});
      chk(2, {16'h0, f4[15:0] & v4[15:0] & exp_mask4});
    end
    // a byte-sized write must leave the register alone
    xfer(1'b1, IE3_ADDR, 32'hffff_ffff, 3'h0);
    rd(IE3_ADDR, {16'h0, v3[15:0] & exp_mask3});
    wr(32'h0000_0020, 32'hffff_ffff);
    rd(32'h0000_0020, 32'h0);
    // interrupt raised, masked, enabled, cleared
    flag3 <= 16'h0;
    flag4 <= 16'h0;
    wr(IRQ_EN_ADDR, 32'h0);
    wr(IE3_ADDR, 32'h0);
    wr(IE4_ADDR, 32'h0000_0100);
    wr(CLEAR_ADDR, 32'hffff_ffff);
    rd(STATUS_ADDR, 32'h0);
    flag4 <= 16'h0100;
    flag3 <= 16'h4066;
    chk(3, 32'h0);
    rd(STATUS_ADDR, 32'h0100_0000);
    wr(IRQ_EN_ADDR, 32'hffff_ffff);
    rd(IRQ_EN_ADDR, 32'hffff_ffff);
    chk(3, 32'h1);
    // clear while the source is still active: the event wins
    wr(CLEAR_ADDR, 32'h0100_0000);
    rd(STATUS_ADDR, 32'h0100_0000);
    flag4 <= 16'h0;
    flag3 <= 16'h0;
    wr(CLEAR_ADDR, 32'h0100_0000);
    rd(STATUS_ADDR, 32'h0);
    rd(CLEAR_ADDR, 32'h0);
    chk(3, 32'h0);
    summarize();
  end

endmodule : tb_top
